// [src/sb_bridge_consts.svh]
// Register offsets, field positions and reset values of the bridge window block
`ifndef SB_BRIDGE_CONSTS_SVH
`define SB_BRIDGE_CONSTS_SVH

// Register byte offsets
`define SB_OFS_SEC      8'h1c
`define SB_OFS_MEM      8'h20
`define SB_OFS_PREF     8'h24
`define SB_OFS_CTRL     8'h40
`define SB_OFS_IRQ_ST   8'h44
`define SB_OFS_IRQ_MSK  8'h48

// Secondary status bit positions in the 0x1c word
`define SB_BIT_FAST66   21
`define SB_BIT_FBB      23
`define SB_BIT_MDPE     24
`define SB_TIM_MSB      26
`define SB_TIM_LSB      25
`define SB_BIT_STA      27
`define SB_BIT_RTA      28
`define SB_BIT_RMA      29
`define SB_BIT_RSE      30
`define SB_BIT_DPE      31

// Window fields
`define SB_BASE_MSB     15
`define SB_BASE_LSB     4
`define SB_LIM_MSB      31
`define SB_LIM_LSB      20
`define SB_PREF_CAP     4'h1
`define SB_FLD_RST      12'h000
`define SB_UPPER_ZERO   32'h0000_0000

// Control word bits
`define SB_BIT_PERR_EN  0
`define SB_BIT_SERR_EN  1

// Event bits in the interrupt status and mask words
`define SB_NEV          6
`define SB_EV_MDPE      0
`define SB_EV_STA       1
`define SB_EV_RTA       2
`define SB_EV_RMA       3
`define SB_EV_RSE       4
`define SB_EV_DPE       5
`define SB_EV_RST       6'h00

`endif

// [src/sb_bridge_regs.sv]
// Secondary status flags and memory windows of a bridge port, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "sb_bridge_consts.svh"

module sb_bridge_regs
   import sb_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // Secondary side events, one-cycle pulses
   input  wire logic        ev_parity,
   input  wire logic        ev_ca_sent,
   input  wire logic        ev_ca_recv,
   input  wire logic        ev_ur_recv,
   input  wire logic        ev_errmsg_sent,
   input  wire logic        ev_poison_recv,
   // Prefetch window parts held elsewhere
   input  wire logic [31:0] pref_base_upper,
   input  wire logic [31:0] pref_limit_upper,
   input  wire logic [11:0] pref_limit_low,
   // Transaction to steer
   input  wire logic        txn_valid,
   input  wire logic [63:0] txn_addr,
   // Forwarding decision, one cycle after the request
   output var  logic        fwd_valid,
   output var  logic        fwd_mem,
   output var  logic        fwd_pref,
   // Interrupt
   output var  logic        irq
);

   sb_state_t     state_reg;
   sb_state_t     state_next;
   logic          take;
   logic          dp_write_reg;
   logic [7:0]    dp_ofs_reg;
   logic          dp_far_reg;
   logic          wr_go;
   logic          rd_go;
   logic [31:0]   rd_val;
   logic [31:0]   hrdata_reg;
   sb_field_t     mem_base_reg;
   sb_field_t     mem_lim_reg;
   sb_field_t     pref_base_reg;
   logic          perr_en_reg;
   logic          serr_en_reg;
   logic          mdpe_reg;
   logic          sta_reg;
   logic          rta_reg;
   logic          rma_reg;
   logic          rse_reg;
   logic          dpe_reg;
   logic [5:0]    ev_set;
   logic [5:0]    irq_st_reg;
   logic [5:0]    irq_msk_reg;
   logic [15:0]   sec_word;
   logic [43:0]   pbase_full;
   logic [43:0]   plim_full;
   logic [43:0]   txn_top;
   logic          mem_hit;
   logic          pref_hit;
   logic          fwd_valid_reg;
   logic          fwd_mem_reg;
   logic          fwd_pref_reg;
   logic          hsize_word;

   // Address phase taken while the slave is not stalling
   assign take      = hsel && hready && htrans[1] && (state_reg != SB_WAIT);
   assign wr_go     = (state_reg == SB_WAIT) && dp_write_reg && !dp_far_reg;
   assign rd_go     = (state_reg == SB_WAIT) && !dp_write_reg;
   assign hsize_word = (hsize == 3'b010);
   assign hreadyout = (state_reg != SB_WAIT);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // One wait state per transfer; writes land before the next address phase,
   // so a read right after a write always sees the new value
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SB_IDLE: begin
            if (take) begin
               state_next = SB_WAIT;
            end
         end
         SB_WAIT: begin
            state_next = SB_DONE;
         end
         SB_DONE: begin
            if (take) begin
               state_next = SB_WAIT;
            end else begin
               state_next = SB_IDLE;
            end
         end
         default: begin
            state_next = SB_IDLE;
         end
      endcase
   end

   // Bus state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= SB_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Address phase capture; addresses above the first 256 bytes are unmapped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_reg <= 1'b0;
         dp_ofs_reg   <= 8'h00;
         dp_far_reg   <= 1'b0;
      end else if (take) begin
         dp_write_reg <= hwrite;
         dp_ofs_reg   <= haddr[7:0];
         dp_far_reg   <= (|haddr[31:8]) || !hsize_word;
      end
   end

   // Secondary status upper half; hardwired legacy bits stay zero
   always_comb begin
      sec_word = 16'h0000;
      sec_word[`SB_BIT_FAST66 - 16] = 1'b0;
      sec_word[`SB_BIT_FBB - 16]    = 1'b0;
      sec_word[`SB_BIT_MDPE - 16]   = mdpe_reg;
      sec_word[`SB_BIT_STA - 16]    = sta_reg;
      sec_word[`SB_BIT_RTA - 16]    = rta_reg;
      sec_word[`SB_BIT_RMA - 16]    = rma_reg;
      sec_word[`SB_BIT_RSE - 16]    = rse_reg;
      sec_word[`SB_BIT_DPE - 16]    = dpe_reg;
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      if (dp_far_reg) begin
         rd_val = 32'h0000_0000;
      end else if (dp_ofs_reg == `SB_OFS_SEC) begin
         rd_val = {sec_word, 16'h0000};
      end else if (dp_ofs_reg == `SB_OFS_MEM) begin
         rd_val = {mem_lim_reg, 4'h0, mem_base_reg, 4'h0};
      end else if (dp_ofs_reg == `SB_OFS_PREF) begin
         rd_val = {16'h0000, pref_base_reg, `SB_PREF_CAP};
      end else if (dp_ofs_reg == `SB_OFS_CTRL) begin
         rd_val = {30'h0000_0000, serr_en_reg, perr_en_reg};
      end else if (dp_ofs_reg == `SB_OFS_IRQ_ST) begin
         rd_val = {26'h000_0000, irq_st_reg};
      end else if (dp_ofs_reg == `SB_OFS_IRQ_MSK) begin
         rd_val = {26'h000_0000, irq_msk_reg};
      end
   end

   // Read data registered at the end of the wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_go) begin
         hrdata_reg <= rd_val;
      end
   end

   // Window fields; only bits 31:20 of the memory edges and the prefetch base are storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_base_reg  <= `SB_FLD_RST;
         mem_lim_reg   <= `SB_FLD_RST;
         pref_base_reg <= `SB_FLD_RST;
      end else if (wr_go) begin
         if (dp_ofs_reg == `SB_OFS_MEM) begin
            mem_base_reg <= hwdata[`SB_BASE_MSB:`SB_BASE_LSB];
            mem_lim_reg  <= hwdata[`SB_LIM_MSB:`SB_LIM_LSB];
         end else if (dp_ofs_reg == `SB_OFS_PREF) begin
            pref_base_reg <= hwdata[`SB_BASE_MSB:`SB_BASE_LSB];
         end
      end
   end

   // Enables for parity response and system error reporting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         perr_en_reg <= 1'b0;
         serr_en_reg <= 1'b0;
      end else if (wr_go && (dp_ofs_reg == `SB_OFS_CTRL)) begin
         perr_en_reg <= hwdata[`SB_BIT_PERR_EN];
         serr_en_reg <= hwdata[`SB_BIT_SERR_EN];
      end
   end

   // Qualified events, in interrupt bit order
   always_comb begin
      ev_set = `SB_EV_RST;
      ev_set[`SB_EV_MDPE] = ev_parity && perr_en_reg;
      ev_set[`SB_EV_STA]  = ev_ca_sent;
      ev_set[`SB_EV_RTA]  = ev_ca_recv;
      ev_set[`SB_EV_RMA]  = ev_ur_recv;
      ev_set[`SB_EV_RSE]  = ev_errmsg_sent && serr_en_reg;
      ev_set[`SB_EV_DPE]  = ev_poison_recv;
   end

   // Write-one-to-clear status flags; a set in the clearing cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mdpe_reg <= 1'b0;
         rse_reg  <= 1'b0;
         dpe_reg  <= 1'b0;
      end else begin
         if (wr_go && (dp_ofs_reg == `SB_OFS_SEC)) begin
            mdpe_reg <= (mdpe_reg && !hwdata[`SB_BIT_MDPE]) || ev_set[`SB_EV_MDPE];
            rse_reg  <= (rse_reg && !hwdata[`SB_BIT_RSE]) || ev_set[`SB_EV_RSE];
            dpe_reg  <= (dpe_reg && !hwdata[`SB_BIT_DPE]) || ev_set[`SB_EV_DPE];
         end else begin
            mdpe_reg <= mdpe_reg || ev_set[`SB_EV_MDPE];
            rse_reg  <= rse_reg || ev_set[`SB_EV_RSE];
            dpe_reg  <= dpe_reg || ev_set[`SB_EV_DPE];
         end
      end
   end

   // Read-only abort flags; software writes cannot touch them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sta_reg <= 1'b0;
         rta_reg <= 1'b0;
         rma_reg <= 1'b0;
      end else begin
         sta_reg <= sta_reg || ev_set[`SB_EV_STA];
         rta_reg <= rta_reg || ev_set[`SB_EV_RTA];
         rma_reg <= rma_reg || ev_set[`SB_EV_RMA];
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st_reg <= `SB_EV_RST;
      end else if (wr_go && (dp_ofs_reg == `SB_OFS_IRQ_ST)) begin
         irq_st_reg <= (irq_st_reg & ~hwdata[5:0]) | ev_set;
      end else begin
         irq_st_reg <= irq_st_reg | ev_set;
      end
   end

   // Interrupt mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_msk_reg <= `SB_EV_RST;
      end else if (wr_go && (dp_ofs_reg == `SB_OFS_IRQ_MSK)) begin
         irq_msk_reg <= hwdata[5:0];
      end
   end

   assign irq = |(irq_st_reg & irq_msk_reg);

   // Window compare on address bits 63:20; the low bits are implied
   // zeros at the base and ones at the limit, so they never matter
   assign pbase_full = {pref_base_upper, pref_base_reg};
   assign plim_full  = {pref_limit_upper, pref_limit_low};
   assign txn_top    = txn_addr[63:20];
   assign mem_hit    = (txn_addr[63:32] == `SB_UPPER_ZERO)
                       && (mem_base_reg <= mem_lim_reg)
                       && (txn_addr[31:20] >= mem_base_reg)
                       && (txn_addr[31:20] <= mem_lim_reg);
   assign pref_hit   = (pbase_full <= plim_full)
                       && (txn_top >= pbase_full)
                       && (txn_top <= plim_full);

   // Decision registered so it is stable for the whole next cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwd_valid_reg <= 1'b0;
         fwd_mem_reg   <= 1'b0;
         fwd_pref_reg  <= 1'b0;
      end else begin
         fwd_valid_reg <= txn_valid;
         fwd_mem_reg   <= txn_valid && mem_hit;
         fwd_pref_reg  <= txn_valid && pref_hit;
      end
   end

   assign fwd_valid = fwd_valid_reg;
   assign fwd_mem   = fwd_mem_reg;
   assign fwd_pref  = fwd_pref_reg;

   // Checks
   chk_legacy_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_go && !dp_far_reg && (dp_ofs_reg == `SB_OFS_SEC)
      |=> (hrdata[`SB_BIT_FAST66] == 1'b0) && (hrdata[`SB_BIT_FBB] == 1'b0)
          && (hrdata[`SB_TIM_MSB:`SB_TIM_LSB] == 2'b00))
      else $error("legacy status bits not zero");

   chk_mdpe_set: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_parity && perr_en_reg |=> mdpe_reg && irq_st_reg[`SB_EV_MDPE])
      else $error("parity flag missed");
   chk_mdpe_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(mdpe_reg) |-> $past(perr_en_reg))
      else $error("parity flag set while disabled");
   chk_sta_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      sta_reg |=> sta_reg)
      else $error("abort sent flag cleared");
   chk_rta_set: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_ca_recv |=> rta_reg [*2])
      else $error("abort received flag missed");
   chk_rma_set: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_ur_recv |=> rma_reg && irq_st_reg[`SB_EV_RMA])
      else $error("unsupported request flag missed");
   chk_rse_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(rse_reg) |-> $past(serr_en_reg && ev_errmsg_sent))
      else $error("system error flag without cause");
   chk_dpe_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (dp_ofs_reg == `SB_OFS_SEC) && hwdata[`SB_BIT_DPE] && !ev_poison_recv
      |=> !dpe_reg)
      else $error("poison flag not cleared");

   chk_mem_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (dp_ofs_reg == `SB_OFS_MEM)
      |=> (mem_base_reg == $past(hwdata[15:4])) && (mem_lim_reg == $past(hwdata[31:20])))
      else $error("memory window write lost");

   chk_pref_cap: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_go && !dp_far_reg && (dp_ofs_reg == `SB_OFS_PREF)
      |=> (hrdata[3:0] == `SB_PREF_CAP) && (hrdata[15:4] == pref_base_reg))
      else $error("prefetch base read wrong");

   chk_mem_empty: assert property (@(posedge hclk) disable iff (!hresetn)
      txn_valid && (mem_base_reg > mem_lim_reg) |=> fwd_valid && !fwd_mem)
      else $error("empty window forwarded");

   chk_ready_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      take |=> !hreadyout ##1 hreadyout)
      else $error("wait state length wrong");

endmodule : sb_bridge_regs
`default_nettype wire

// [src/sb_pkg.sv]
// Types shared by the bridge window block
package sb_pkg;

   // Bus slave data phase, Gray coded along idle, wait, done
   typedef enum logic [1:0] {
      SB_IDLE = 2'b00,
      SB_WAIT = 2'b01,
      SB_DONE = 2'b11
   } sb_state_t;

   // Address bits 31:20 of a window edge
   typedef logic [11:0] sb_field_t;

endpackage : sb_pkg

// [tb/testbench.sv]
// Self-checking bench for the bridge status and window register block
`timescale 1ns/1ps
`default_nettype none
`include "sb_bridge_consts.svh"

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module testbench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [5:0]  ev = 6'h0;
   logic [31:0] pbu = 32'h0;
   logic [31:0] plu = 32'h0;
   logic [11:0] pll = 12'h0;
   logic        txn_valid = 1'b0;
   logic [63:0] txn_addr = 64'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        fwd_valid;
   logic        fwd_mem;
   logic        fwd_pref;
   logic        irq;
   logic [31:0] seed = 32'ha82210fb;
   logic [11:0] mb = 12'h0;
   logic [11:0] ml = 12'h0;
   logic [11:0] pb = 12'h0;
   logic        rd_pend = 1'b0;
   logic [31:0] rdq[$];
   logic [1:0]  fwq[$];
   logic [31:0] exp_rd;
   logic [1:0]  exp_fw;
   int          n_fail = 0;
   int          check_count = 0;
   // Address bits 63:20 probed: memory window edges, then prefetch edges above 4 GB
   logic [43:0] edges[8] = '{44'h00000100, 44'h000001ff, 44'h000000ff, 44'h00000200,
                             44'h00000001400, 44'h000000017ff, 44'h00000001800, 44'h000000013ff};

   always #5 hclk = ~hclk;

   sb_bridge_regs i_sb_bridge_regs (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ev_parity(ev[0]), .ev_ca_sent(ev[1]), .ev_ca_recv(ev[2]), .ev_ur_recv(ev[3]),
      .ev_errmsg_sent(ev[4]), .ev_poison_recv(ev[5]),
      .pref_base_upper(pbu), .pref_limit_upper(plu), .pref_limit_low(pll),
      .txn_valid(txn_valid), .txn_addr(txn_addr),
      .fwd_valid(fwd_valid), .fwd_mem(fwd_mem), .fwd_pref(fwd_pref), .irq(irq));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // Window decision worked out from the programmed edges; an inverted pair is empty
   function automatic logic [1:0] fwd_exp(input logic [63:0] a);
      logic m;
      logic p;
      m = (a[63:32] == 32'h0) && (mb <= a[31:20]) && (a[31:20] <= ml) && (mb <= ml);
      p = ({pbu, pb} <= a[63:20]) && (a[63:20] <= {plu, pll}) && ({pbu, pb} <= {plu, pll});
      return {m, p};
   endfunction : fwd_exp

   // One single transfer at the current hsize; the read expectation is noted once the address is taken
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (!hreadyout);
      if (!w) rdq.push_back(e);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= w ? d : xs();
      do @(posedge hclk); while (!hreadyout);
   endtask : bus

   task automatic pulse(input int i);
      ev <= 6'h01 << i;
      @(posedge hclk);
      ev <= 6'h00;
      @(posedge hclk);
   endtask : pulse

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   // Output watcher: read data at the end of each read, decisions whenever they appear
   always @(posedge hclk) begin
      if (rd_pend && hreadyout) begin
         rd_pend <= 1'b0;
         // Popped once, so a mismatch report cannot eat a second note
         exp_rd = rdq.pop_front();
         `CHK("hrdata", exp_rd, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
      if (hsel && htrans[1] && hreadyout && !hwrite) rd_pend <= 1'b1;
      if (fwd_valid) begin
         exp_fw = (fwq.size() > 0) ? fwq.pop_front() : 2'bxx;
         `CHK("fwd", exp_fw, {fwd_mem, fwd_pref})
      end
   end

   // Watchdog sized well beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      n_fail++;
      conclude();
   end

   initial begin
      logic [63:0] a;
      logic [31:0] r;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values and fixed fields
      bus(0, `SB_OFS_SEC, 0, 32'h0);
      bus(0, `SB_OFS_MEM, 0, 32'h0);
      bus(0, `SB_OFS_PREF, 0, 32'h1);
      bus(0, `SB_OFS_IRQ_ST, 0, 32'h0);
      // Writes land only on the writable fields
      bus(1, `SB_OFS_MEM, 32'hffffffff, 0);
      bus(0, `SB_OFS_MEM, 0, 32'hfff0fff0);
      bus(1, `SB_OFS_PREF, 32'hffffffff, 0);
      bus(0, `SB_OFS_PREF, 0, 32'h0000fff1);
      bus(1, `SB_OFS_SEC, 32'hffffffff, 0);
      bus(0, `SB_OFS_SEC, 0, 32'h0);
      bus(0, 8'h80, 0, 32'h0);
      // Sub-word transfers count as unmapped: write dropped, read zero
      hsize <= 3'h0;
      bus(1, `SB_OFS_MEM, 32'h0, 0);
      bus(0, `SB_OFS_MEM, 0, 32'h0);
      hsize <= 3'h2;
      bus(0, `SB_OFS_MEM, 0, 32'hfff0fff0);
      // Enables off: parity and error-message events are dropped
      pulse(0);
      pulse(4);
      bus(0, `SB_OFS_SEC, 0, 32'h0);
      bus(1, `SB_OFS_CTRL, 32'h3, 0);
      bus(0, `SB_OFS_CTRL, 0, 32'h3);
      bus(1, `SB_OFS_IRQ_MSK, 32'h3f, 0);
      bus(0, `SB_OFS_IRQ_MSK, 0, 32'h3f);
      for (int i = 0; i < 6; i++) begin
         pulse(i);
         `CHK("irq", 1'b1, irq)
         bus(1, `SB_OFS_IRQ_ST, 32'h3f, 0);
      end
      bus(0, `SB_OFS_SEC, 0, 32'hf9000000);
      bus(1, `SB_OFS_SEC, 32'hffffffff, 0);
      bus(0, `SB_OFS_SEC, 0, 32'h38000000);
      // Masked event keeps irq low until unmasked
      bus(1, `SB_OFS_IRQ_MSK, 32'h0, 0);
      pulse(5);
      `CHK("irq", 1'b0, irq)
      bus(0, `SB_OFS_IRQ_ST, 0, 32'h20);
      bus(1, `SB_OFS_IRQ_MSK, 32'h20, 0);
      `CHK("irq", 1'b1, irq)
      bus(1, `SB_OFS_IRQ_ST, 32'h20, 0);
      `CHK("irq", 1'b0, irq)
      // Windows: memory 0x100..0x1ff, prefetch 0x1_400..0x1_7ff, then inverted pairs
      for (int pass = 0; pass < 2; pass++) begin
         mb = pass ? 12'h300 : 12'h100;
         ml = 12'h1ff;
         pb = 12'h400;
         pbu <= 32'h1;
         plu <= pass ? 32'h0 : 32'h1;
         pll <= 12'h7ff;
         bus(1, `SB_OFS_MEM, {ml, 4'hf, mb, 4'hf}, 0);
         bus(1, `SB_OFS_PREF, {16'hffff, pb, 4'h0}, 0);
         for (int k = 0; k < 48; k++) begin
            r = xs();
            a = {edges[k % 8], r[19:0]};
            r = xs();
            txn_valid <= r[0];
            txn_addr  <= a;
            @(posedge hclk);
            if (txn_valid) fwq.push_back(fwd_exp(txn_addr));
         end
         txn_valid <= 1'b0;
         repeat (3) @(posedge hclk);
      end
      `CHK("fwd_left", 0, fwq.size())
      conclude();
   end
endmodule : testbench

`default_nettype wire
